// >>> rcc_consts.vh
// Purpose: Shared constants of the radio transmit-side control block.
// Assumes: Included by rcc_top.v and the bench by bare name, not by rcc_txbuf.v.
// Notes: Register offsets are byte addresses on a 32-bit APB bus.
`ifndef RCC_CONSTS_VH
`define RCC_CONSTS_VH

// Register byte offsets.
`define RCC_OFS_CTRL 8'h00
`define RCC_OFS_THRESH 8'h04
`define RCC_OFS_SYNTH_HI 8'h08
`define RCC_OFS_SYNTH_LO 8'h0c
`define RCC_OFS_TXPWR 8'h10
`define RCC_OFS_DAC 8'h14
`define RCC_OFS_STROBE 8'h18
`define RCC_OFS_STATUS 8'h1c
`define RCC_OFS_IRQ 8'h20
`define RCC_OFS_TXBUF 8'h24

// Control and DAC register fields.
`define RCC_CRIT_LSB 0
`define RCC_CRIT_MSB 1
`define RCC_TSEL_LSB 2
`define RCC_TSEL_MSB 3
`define RCC_DAC_EN_BIT 16

// Strobe bits.
`define RCC_STB_TX 0
`define RCC_STB_TXCCA 1
`define RCC_STB_RX 2
`define RCC_STB_OFF 3
`define RCC_STB_ACK 4

// Clear channel criterion codes.
`define RCC_CRIT_ENERGY 2'h1
`define RCC_CRIT_NOFRAME 2'h2
`define RCC_CRIT_BOTH 2'h3

// Transmit test selector codes.
`define RCC_TSEL_NORMAL 2'h0
`define RCC_TSEL_REPLAY 2'h2
`define RCC_TSEL_PRBS 2'h3

// Reset values.
`define RCC_RST_CRIT 2'h3
`define RCC_RST_THRESH 8'he0
`define RCC_RST_SYNTH 10'h165
`define RCC_RST_TXPWR 8'hff
`define RCC_RST_DAC 16'h0000

// Synthesizer receive offset in frequency-word steps of 1 MHz.
`define RCC_IF_OFFSET 10'h002

// CRC generator for the pseudo-random pattern.
`define RCC_CRC_POLY 16'h8408
`define RCC_CRC_INIT 16'h0000
`define RCC_PRBS_FEED 8'hff

// Synchronization header.
`define RCC_PREAMBLE_BYTES 3'h4
`define RCC_PREAMBLE_BYTE 8'h00
`define RCC_SFD_BYTE 8'ha7

// Timing: clock period and symbol period in ns.
`define RCC_CLK_NS 20
`define RCC_SYMBOL_NS 16000
`define RCC_CCA_SYMBOLS 8
`define RCC_CAL_NS 192000

`endif

// >>> rcc_txbuf.v
// Purpose: Transmit buffer memory, one write port and one registered read port.
// Assumes: Single clock, clock enable freezes both ports.
// Notes: Read data appear one edge after the address.
`timescale 1ns/100ps
module rcc_txbuf #(
  parameter DW = 8,
  parameter AW = 7
) (
  // Clock.
  input wire clk,
  input wire ce,
  // Write port.
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // Read port.
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Storage with a registered read so synthesis can map it to block RAM.
  always @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule // rcc_txbuf

// >>> rcc_top.v
// Purpose: Radio transmit-side control: clear channel check, synthesizer word,
//   calibration sequencing, power setting and transmit test patterns.
// Assumes: APB slave on CLK at 50 MHz; radio pins are asynchronous to CLK.
// Notes: Bytes leave on TX_BYTE when the modulator asks with BYTE_REQ_IN.
//
// What this block does
// (RULE1) Two-bit criterion picks energy, no-frame, or both; code 00 is reserved.
// (RULE2) Clear result is an active-high status bit and sets its interrupt flag.
// (RULE3) Conditional transmit strobe starts sending only when the channel is clear.
// (RULE4) Transmit-active status shows whether a conditional transmit really started.
// (RULE5) Software loads word 357 plus five times channel minus 11.
// (RULE6) Receive offset is applied by hardware, one word serves both directions.
// (RULE7) Every receive, transmit or acknowledge enable passes a calibration state.
// (RULE8) Power control register sets output level, 0xFF highest, 0x03 lowest.
// (RULE9) Software should program power control with 0x5F for best link quality.
// (RULE10) Bias output is low in receive and high in transmit.
// (RULE11) Software resets, selects crystal clock, waits for stability before test modes.
// (RULE12) Selector 2 with DAC override 0x1800 and transmit gives static DACs.
// (RULE13) Selector 3 sends CRC low byte, updating the CRC with 0xFF.
// (RULE14) Pseudo-random sequence repeats every 65535 bits, starting 0x00, 0x78.
// (RULE15) A synchronization header precedes data in every transmit mode.
// (RULE16) Selector 2 without override replays the whole buffer ignoring underflow.
// (RULE17) Clear result counts as valid only after 8 symbols of receive.
// (RULE18) Ten-bit word in high and low registers, carrier 2048 plus word MHz.
// (RULE19) Energy threshold is programmed in steps of 1 dB.
// (RULE20) Normal selector sends buffered frame bytes and stops at frame end.
`timescale 1ns/100ps
`include "rcc_consts.vh"
module rcc_top #(
  parameter BUF_AW = 7,
  parameter CCA_WAIT_CYC = `RCC_CCA_SYMBOLS * `RCC_SYMBOL_NS / `RCC_CLK_NS,
  parameter CAL_CYC = `RCC_CAL_NS / `RCC_CLK_NS
) (
  // Clock, reset and clock enable.
  input wire CLK,
  input wire RST,
  input wire CE,
  // APB slave.
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Receiver and modulator inputs, asynchronous.
  input wire [7:0] RSSI_IN,
  input wire RX_FRAME_IN,
  input wire BYTE_REQ_IN,
  // Transmit path outputs.
  output reg [7:0] TX_BYTE,
  output reg TX_BYTE_VALID,
  output reg TX_ON,
  output reg TR_BIAS,
  output reg CAL_ON,
  output reg DAC_OVR,
  output reg [15:0] DAC_VALUE,
  output reg [7:0] PA_LEVEL,
  output reg [9:0] LO_WORD
);
  // Controller states.
  localparam ST_IDLE = 3'h0;
  localparam ST_RXCAL = 3'h1;
  localparam ST_RX = 3'h2;
  localparam ST_TXCAL = 3'h3;
  localparam ST_SHR = 3'h4;
  localparam ST_DATA = 3'h5;

  // One CRC update by a whole byte, LSB first.
  function [15:0] crc_byte;
    input [15:0] crc;
    input [7:0] din;
    reg [15:0] c;
    integer i;
    begin
      c = crc;
      for (i = 0; i < 8; i = i + 1) begin
        if (c[0] ^ din[i]) begin
          c = (c >> 1) ^ `RCC_CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      crc_byte = c;
    end
  endfunction

  // Software registers.
  reg [1:0] criterion;
  reg [1:0] tsel;
  reg [7:0] thresh;
  reg [9:0] synth_word;
  reg [7:0] txpwr;
  reg [15:0] dac_word;
  reg dac_en;
  reg irq_flag;
  reg [BUF_AW-1:0] wr_ptr;
  reg [BUF_AW:0] fill;

  // Controller state.
  reg [2:0] state;
  reg [31:0] timer;
  reg rx_ready;
  reg cca;
  reg cca_q;
  reg [2:0] shr_cnt;
  reg [BUF_AW-1:0] rd_ptr;
  reg [15:0] crc;

  // Pin synchronisers; logic reads the second stage, and req_s3 for the request edge.
  reg [7:0] rssi_s1;
  reg [7:0] rssi_s2;
  reg frame_s1;
  reg frame_s2;
  reg req_s1;
  reg req_s2;
  reg req_s3;

  wire [7:0] buf_rdata;
  wire apb_wr = PSEL && PENABLE && PREADY && PWRITE;
  wire stb_wr = apb_wr && (PADDR == `RCC_OFS_STROBE);
  wire buf_wr = apb_wr && (PADDR == `RCC_OFS_TXBUF);
  wire byte_req = req_s2 && !req_s3;
  wire energy_low = $signed(rssi_s2) < $signed(thresh); // RULE19
  wire replay = (tsel == `RCC_TSEL_REPLAY) && !dac_en;
  wire tx_busy = (state == ST_TXCAL) || (state == ST_SHR) || (state == ST_DATA);
  reg next_cca;
  reg [31:0] rd_mux;
  reg map_hit;

  rcc_txbuf #(
    .DW(8),
    .AW(BUF_AW)
  ) rcc_txbuf_i (
    .clk(CLK),
    .ce(CE),
    .wr_en(buf_wr),
    .wr_addr(wr_ptr),
    .wr_data(PWDATA[7:0]),
    .rd_addr(rd_ptr),
    .rd_data(buf_rdata)
  );

  // Criterion decode; the reserved code never reports a clear channel.
  always @* begin
    case (criterion) // RULE1
      `RCC_CRIT_ENERGY: next_cca = energy_low;
      `RCC_CRIT_NOFRAME: next_cca = !frame_s2;
      `RCC_CRIT_BOTH: next_cca = energy_low && !frame_s2;
      default: next_cca = 1'b0;
    endcase
  end

  // Two flip-flops per pin before any logic looks at it.
  always @(posedge CLK) begin
    if (RST) begin
      rssi_s1 <= 8'h00;
      rssi_s2 <= 8'h00;
      frame_s1 <= 1'b0;
      frame_s2 <= 1'b0;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else if (CE) begin
      rssi_s1 <= RSSI_IN;
      rssi_s2 <= rssi_s1;
      frame_s1 <= RX_FRAME_IN;
      frame_s2 <= frame_s1;
      req_s1 <= BYTE_REQ_IN;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // Read mux for the APB setup phase.
  always @* begin
    rd_mux = 32'h0000_0000;
    map_hit = 1'b1;
    case (PADDR)
      `RCC_OFS_CTRL: rd_mux = {28'h0000000, tsel, criterion};
      `RCC_OFS_THRESH: rd_mux = {24'h000000, thresh};
      `RCC_OFS_SYNTH_HI: rd_mux = {30'h00000000, synth_word[9:8]};
      `RCC_OFS_SYNTH_LO: rd_mux = {24'h000000, synth_word[7:0]};
      `RCC_OFS_TXPWR: rd_mux = {24'h000000, txpwr};
      `RCC_OFS_DAC: rd_mux = {15'h0000, dac_en, dac_word};
      `RCC_OFS_STROBE: rd_mux = 32'h0000_0000;
      `RCC_OFS_STATUS: rd_mux = {25'h0000000, fill[BUF_AW:0] == 0, state, rx_ready, tx_busy, cca}; // RULE2 RULE4
      `RCC_OFS_IRQ: rd_mux = {31'h00000000, irq_flag};
      `RCC_OFS_TXBUF: rd_mux = 32'h0000_0000;
      default: map_hit = 1'b0;
    endcase
  end

  // APB slave: answers with PREADY in the first access cycle.
  always @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !map_hit;
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= rd_mux;
      end
    end
  end

  // Software-written registers; writes take effect at the completing edge.
  always @(posedge CLK) begin
    if (RST) begin
      criterion <= `RCC_RST_CRIT;
      tsel <= `RCC_TSEL_NORMAL;
      thresh <= `RCC_RST_THRESH;
      synth_word <= `RCC_RST_SYNTH;
      txpwr <= `RCC_RST_TXPWR;
      dac_word <= `RCC_RST_DAC;
      dac_en <= 1'b0;
    end else if (CE && apb_wr) begin
      case (PADDR)
        `RCC_OFS_CTRL: begin
          criterion <= PWDATA[`RCC_CRIT_MSB:`RCC_CRIT_LSB];
          tsel <= PWDATA[`RCC_TSEL_MSB:`RCC_TSEL_LSB];
        end
        `RCC_OFS_THRESH: thresh <= PWDATA[7:0];
        `RCC_OFS_SYNTH_HI: synth_word[9:8] <= PWDATA[1:0]; // RULE18
        `RCC_OFS_SYNTH_LO: synth_word[7:0] <= PWDATA[7:0]; // RULE18
        `RCC_OFS_TXPWR: txpwr <= PWDATA[7:0];
        `RCC_OFS_DAC: begin
          dac_word <= PWDATA[15:0];
          dac_en <= PWDATA[`RCC_DAC_EN_BIT];
        end
        default: ;
      endcase
    end
  end

  // Clear channel flag, valid only once receive has run long enough.
  always @(posedge CLK) begin
    if (RST) begin
      cca <= 1'b0;
      cca_q <= 1'b0;
      irq_flag <= 1'b0;
    end else if (CE) begin
      cca <= rx_ready && next_cca; // RULE17
      cca_q <= cca;
      // A new event in the clearing cycle keeps the flag set.
      if (cca && !cca_q) begin
        irq_flag <= 1'b1; // RULE2
      end else if (apb_wr && (PADDR == `RCC_OFS_IRQ) && PWDATA[0]) begin
        irq_flag <= 1'b0;
      end
    end
  end

  // Main controller: calibration, header, data and receive timing.
  always @(posedge CLK) begin
    if (RST) begin
      state <= ST_IDLE;
      timer <= 32'h0000_0000;
      rx_ready <= 1'b0;
      shr_cnt <= 3'h0;
      rd_ptr <= {BUF_AW{1'b0}};
      wr_ptr <= {BUF_AW{1'b0}};
      fill <= {(BUF_AW+1){1'b0}};
      crc <= `RCC_CRC_INIT;
      TX_BYTE <= 8'h00;
      TX_BYTE_VALID <= 1'b0;
    end else if (CE) begin
      TX_BYTE_VALID <= 1'b0;
      if (buf_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
        if (fill[BUF_AW] == 1'b0) begin
          fill <= fill + 1'b1;
        end
      end
      if (stb_wr && PWDATA[`RCC_STB_OFF]) begin
        state <= ST_IDLE;
        rx_ready <= 1'b0;
      end else if (stb_wr && (PWDATA[`RCC_STB_TX] || PWDATA[`RCC_STB_ACK] ||
                              (PWDATA[`RCC_STB_TXCCA] && cca))) begin // RULE3
        state <= ST_TXCAL; // RULE7
        timer <= 32'h0000_0000;
        rx_ready <= 1'b0;
      end else if (stb_wr && PWDATA[`RCC_STB_RX] && !tx_busy) begin
        state <= ST_RXCAL; // RULE7
        timer <= 32'h0000_0000;
        rx_ready <= 1'b0;
      end else begin
        case (state)
          ST_RXCAL: begin
            timer <= timer + 1'b1;
            if (timer >= CAL_CYC - 1) begin
              state <= ST_RX;
              timer <= 32'h0000_0000;
            end
          end
          ST_RX: begin
            if (timer >= CCA_WAIT_CYC - 1) begin
              rx_ready <= 1'b1; // RULE17
            end else begin
              timer <= timer + 1'b1;
            end
          end
          ST_TXCAL: begin
            timer <= timer + 1'b1;
            if (timer >= CAL_CYC - 1) begin
              state <= ST_SHR;
              shr_cnt <= 3'h0;
              crc <= `RCC_CRC_INIT;
              rd_ptr <= replay ? {BUF_AW{1'b0}} : wr_ptr - fill[BUF_AW-1:0];
            end
          end
          ST_SHR: begin
            // Header goes out in every mode, test patterns included.
            if (byte_req) begin // RULE15
              TX_BYTE_VALID <= 1'b1;
              if (shr_cnt == `RCC_PREAMBLE_BYTES) begin
                TX_BYTE <= `RCC_SFD_BYTE;
                state <= ST_DATA;
              end else begin
                TX_BYTE <= `RCC_PREAMBLE_BYTE;
                shr_cnt <= shr_cnt + 1'b1;
              end
            end
          end
          ST_DATA: begin
            if (byte_req) begin
              if (dac_en && (tsel == `RCC_TSEL_REPLAY)) begin
                TX_BYTE_VALID <= 1'b0; // RULE12
              end else if (tsel == `RCC_TSEL_PRBS) begin
                TX_BYTE <= crc[7:0]; // RULE13 RULE14
                TX_BYTE_VALID <= 1'b1;
                crc <= crc_byte(crc, `RCC_PRBS_FEED); // RULE13
              end else if (replay) begin
                // Pointer wraps over all entries; underflow is ignored.
                TX_BYTE <= buf_rdata; // RULE16
                TX_BYTE_VALID <= 1'b1;
                rd_ptr <= rd_ptr + 1'b1;
              end else if (fill == 0) begin
                state <= ST_IDLE; // RULE20
              end else begin
                TX_BYTE <= buf_rdata; // RULE20
                TX_BYTE_VALID <= 1'b1;
                rd_ptr <= rd_ptr + 1'b1;
                // A push in the same cycle cancels this pop.
                fill <= buf_wr ? fill : fill - 1'b1;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Radio-facing levels, all registered.
  always @(posedge CLK) begin
    if (RST) begin
      TX_ON <= 1'b0;
      TR_BIAS <= 1'b0;
      CAL_ON <= 1'b0;
      DAC_OVR <= 1'b0;
      DAC_VALUE <= `RCC_RST_DAC;
      PA_LEVEL <= `RCC_RST_TXPWR;
      LO_WORD <= `RCC_RST_SYNTH - `RCC_IF_OFFSET; // RULE6
    end else if (CE) begin
      TX_ON <= tx_busy; // RULE4
      TR_BIAS <= tx_busy; // RULE10
      CAL_ON <= (state == ST_RXCAL) || (state == ST_TXCAL); // RULE7
      DAC_OVR <= (state == ST_DATA) && dac_en && (tsel == `RCC_TSEL_REPLAY); // RULE12
      DAC_VALUE <= dac_word; // RULE12
      PA_LEVEL <= txpwr;
      // Receive uses the local oscillator below the carrier by the IF.
      LO_WORD <= tx_busy ? synth_word : synth_word - `RCC_IF_OFFSET; // RULE6
    end
  end
endmodule // rcc_top

// >>> rcc_top_checker.sv
// Purpose: Port-level checks on the radio transmit control block.
// Assumes: The bench drops CE only while no bus transfer is open.
// Notes: Bound into rcc_top below the module.
`timescale 1ns/100ps
module rcc_checker #(
  parameter BUF_AW = 7,
  parameter CCA_WAIT_CYC = 20,
  parameter CAL_CYC = 8
) (
  // Clock and reset.
  input wire CLK,
  input wire RST,
  input wire CE,
  // Bus handshake.
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  // Radio side.
  input wire TX_BYTE_VALID,
  input wire TX_ON,
  input wire TR_BIAS,
  input wire CAL_ON,
  input wire DAC_OVR
);
  // Length of the running calibration; a stuck state would pass a plain level check.
  reg [15:0] cal_run;
  always @(posedge CLK) begin
    if (RST || !CAL_ON) begin
      cal_run <= 16'h0000;
    end else begin
      cal_run <= cal_run + 16'h0001;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_setup;
    PSEL && !PENABLE && CE;
  endsequence
  sequence s_cal_two;
    CAL_ON ##1 CAL_ON;
  endsequence

  a_ready_answer: assert property (s_setup |=> PREADY || !CE)
    else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_bias_tracks_tx: assert property (TR_BIAS == TX_ON)
    else $error("bias differs from transmit");
  a_tx_cal_first: assert property ($rose(TX_ON) |-> s_cal_two)
    else $error("transmit skipped calibration");
  a_cal_length: assert property ($fell(CAL_ON) |-> cal_run >= CAL_CYC - 1 && cal_run <= CAL_CYC + 1)
    else $error("calibration length wrong");
  a_byte_pulse: assert property (TX_BYTE_VALID |=> !TX_BYTE_VALID)
    else $error("byte valid held");
  a_byte_in_tx: assert property (TX_BYTE_VALID |-> TX_ON && !CAL_ON && !DAC_OVR)
    else $error("byte outside send phase");
  a_ovr_in_tx: assert property (DAC_OVR |-> TX_ON)
    else $error("override outside transmit");
endmodule // rcc_checker

bind rcc_top rcc_checker #(.BUF_AW(BUF_AW), .CCA_WAIT_CYC(CCA_WAIT_CYC), .CAL_CYC(CAL_CYC)) rcc_checker_i (
  .CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TX_BYTE_VALID(TX_BYTE_VALID), .TX_ON(TX_ON), .TR_BIAS(TR_BIAS), .CAL_ON(CAL_ON), .DAC_OVR(DAC_OVR));

// >>> tb_rcc_top.sv
// Purpose: Self-checking bench for rcc_top.
// Assumes: Calibration and clear channel waits shortened by parameters.
// Notes: CE drops once, during receive calibration, to show the freeze.
`timescale 1ns/100ps
`include "rcc_consts.vh"
module tb_rcc_top;
  reg CLK, RST, CE, PSEL, PENABLE, PWRITE, RX_FRAME_IN, BYTE_REQ_IN, err;
  reg [7:0] PADDR, RSSI_IN, b;
  reg [31:0] PWDATA, rd;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, TX_BYTE_VALID, TX_ON, TR_BIAS, CAL_ON, DAC_OVR;
  wire [7:0] TX_BYTE, PA_LEVEL;
  wire [15:0] DAC_VALUE;
  wire [9:0] LO_WORD;
  integer fails, samples_checked, i, n, w;
  localparam [55:0] PRBS_HEAD = 56'h0078b84b99c3e9;

  rcc_top #(.BUF_AW(7), .CCA_WAIT_CYC(20), .CAL_CYC(8)) rcc_top_i (.CLK(CLK), .RST(RST), .CE(CE),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RSSI_IN(RSSI_IN), .RX_FRAME_IN(RX_FRAME_IN), .BYTE_REQ_IN(BYTE_REQ_IN),
    .TX_BYTE(TX_BYTE), .TX_BYTE_VALID(TX_BYTE_VALID), .TX_ON(TX_ON), .TR_BIAS(TR_BIAS), .CAL_ON(CAL_ON),
    .DAC_OVR(DAC_OVR), .DAC_VALUE(DAC_VALUE), .PA_LEVEL(PA_LEVEL), .LO_WORD(LO_WORD));

  task test_done;
    begin
      $display("checked %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: saw %h, want %h", $time, got, exp);
      end
    end
  endtask

  // A wait that runs out counts as a mismatch and ends the run.
  task tmo;
    begin
      fails = fails + 1;
      $display("unexpected at %0t: wait ran out", $time);
      test_done;
    end
  endtask

  // One bus transfer; the leading edge keeps back-to-back calls from driving twice in one step.
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
        @(posedge CLK);
        n = n + 1;
      end while (PREADY !== 1'b1 && n < 20);
      if (n >= 20) tmo;
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask

  task rdc(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask

  // Request line stays high at least three edges, then low four.
  task getb;
    begin
      @(posedge CLK);
      BYTE_REQ_IN <= 1'b1;
      n = 0;
      do begin
        @(posedge CLK);
        n = n + 1;
      end while ((TX_BYTE_VALID !== 1'b1 || n < 3) && n < 20);
      if (n >= 20) tmo;
      b = TX_BYTE;
      BYTE_REQ_IN <= 1'b0;
      repeat (4) @(posedge CLK);
    end
  endtask

  task pulse;
    begin
      BYTE_REQ_IN <= 1'b1;
      repeat (4) @(posedge CLK);
      BYTE_REQ_IN <= 1'b0;
      repeat (6) @(posedge CLK);
    end
  endtask

  task wcal;
    begin
      n = 0;
      do begin
        @(posedge CLK);
        n = n + 1;
      end while ((CAL_ON !== 1'b0 || n < 3) && n < 60);
      if (n >= 60) tmo;
    end
  endtask

  task hdr;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        getb;
        chk(32'(b), 32'((i < 4) ? `RCC_PREAMBLE_BYTE : `RCC_SFD_BYTE));
      end
    end
  endtask

  task off;
    begin
      apb(1'b1, `RCC_OFS_STROBE, 32'h8);
      repeat (3) @(posedge CLK);
      chk(32'({TX_ON, TR_BIAS}), 32'h0);
    end
  endtask

  task rst;
    begin
      @(posedge CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
    end
  endtask

  task t_regs;
    begin
      chk(32'(PA_LEVEL), 32'hff);
      chk(32'(LO_WORD), 32'h163);
      rdc(`RCC_OFS_CTRL, 32'h3);
      rdc(`RCC_OFS_THRESH, 32'he0);
      rdc(`RCC_OFS_SYNTH_HI, 32'h1);
      rdc(`RCC_OFS_SYNTH_LO, 32'h65);
      apb(1'b0, 8'h40, 32'h0);
      chk({rd[31:1], err}, 32'h1);
    end
  endtask

  // Every channel word, with the receive offset seen on the oscillator word.
  task t_chan;
    begin
      for (i = 11; i <= 26; i = i + 1) begin
        w = 357 + 5 * (i - 11);
        apb(1'b1, `RCC_OFS_SYNTH_HI, w >> 8);
        apb(1'b1, `RCC_OFS_SYNTH_LO, w & 255);
        rdc(`RCC_OFS_SYNTH_LO, w & 255);
        repeat (2) @(posedge CLK);
        chk(32'(LO_WORD), w - 2);
      end
    end
  endtask

  task t_pwr;
    begin
      apb(1'b1, `RCC_OFS_TXPWR, 32'h5f);
      repeat (2) @(posedge CLK);
      chk(32'(PA_LEVEL), 32'h5f);
      apb(1'b1, `RCC_OFS_TXPWR, 32'h3);
      rdc(`RCC_OFS_TXPWR, 32'h3);
      chk(32'(PA_LEVEL), 32'h3);
    end
  endtask

  // All criterion codes against energy and frame conditions.
  task t_cca;
    integer m, c;
    begin
      apb(1'b1, `RCC_OFS_STROBE, 32'h4);
      // Frozen calibration must still be running after twenty idle-enable cycles.
      CE <= 1'b0;
      repeat (20) @(posedge CLK);
      CE <= 1'b1;
      repeat (2) @(posedge CLK);
      chk(32'({TR_BIAS, CAL_ON}), 32'h1);
      apb(1'b0, `RCC_OFS_STATUS, 32'h0);
      chk(32'(rd[0]), 32'h0);
      repeat (40) @(posedge CLK);
      for (m = 0; m < 5; m = m + 1) begin
        for (c = 0; c < 3; c = c + 1) begin
          apb(1'b1, `RCC_OFS_CTRL, m & 3);
          RSSI_IN <= (c == 1) ? 8'h10 : 8'hc0;
          RX_FRAME_IN <= (c == 2);
          repeat (8) @(posedge CLK);
          apb(1'b0, `RCC_OFS_STATUS, 32'h0);
          w = (m % 4 == 1) ? (c != 1) : (m == 2) ? (c != 2) : (m == 3) && (c == 0);
          chk(32'(rd[0]), w);
        end
      end
      rdc(`RCC_OFS_IRQ, 32'h1);
      apb(1'b1, `RCC_OFS_IRQ, 32'h1);
      rdc(`RCC_OFS_IRQ, 32'h0);
    end
  endtask

  // Conditional send refused on a busy channel, then taken and run to frame end.
  task t_ctx;
    begin
      apb(1'b1, `RCC_OFS_TXBUF, 32'h11);
      apb(1'b1, `RCC_OFS_TXBUF, 32'h22);
      apb(1'b1, `RCC_OFS_CTRL, 32'h1);
      RSSI_IN <= 8'h10;
      repeat (8) @(posedge CLK);
      apb(1'b1, `RCC_OFS_STROBE, 32'h2);
      repeat (8) @(posedge CLK);
      chk(32'(TX_ON), 32'h0);
      apb(1'b0, `RCC_OFS_STATUS, 32'h0);
      chk(32'(rd[1]), 32'h0);
      RSSI_IN <= 8'hc0;
      repeat (8) @(posedge CLK);
      apb(1'b1, `RCC_OFS_STROBE, 32'h2);
      apb(1'b0, `RCC_OFS_STATUS, 32'h0);
      chk(32'(rd[1]), 32'h1);
      chk(32'({TR_BIAS, LO_WORD}), 32'h5b0);
      wcal;
      hdr;
      getb;
      chk(32'(b), 32'h11);
      getb;
      chk(32'(b), 32'h22);
      pulse;
      chk(32'({TX_ON, TR_BIAS}), 32'h0);
    end
  endtask

  task t_prbs;
    begin
      apb(1'b1, `RCC_OFS_CTRL, 32'hf);
      apb(1'b1, `RCC_OFS_STROBE, 32'h1);
      wcal;
      hdr;
      for (i = 0; i < 7; i = i + 1) begin
        getb;
        chk(32'(b), 32'(PRBS_HEAD[55 - 8 * i -: 8]));
      end
      off;
    end
  endtask

  task t_dac;
    begin
      apb(1'b1, `RCC_OFS_DAC, 32'h11800);
      apb(1'b1, `RCC_OFS_CTRL, 32'hb);
      apb(1'b1, `RCC_OFS_STROBE, 32'h10);
      wcal;
      chk(32'(DAC_VALUE), 32'h1800);
      hdr;
      pulse;
      chk(32'({DAC_OVR, TX_ON}), 32'h3);
      off;
    end
  endtask

  // Full buffer replayed past its end to show the wrap from index zero.
  task t_replay;
    begin
      rst;
      apb(1'b1, `RCC_OFS_CTRL, 32'hb);
      for (i = 0; i < 128; i = i + 1) begin
        apb(1'b1, `RCC_OFS_TXBUF, (i * 7 + 3) % 256);
      end
      apb(1'b1, `RCC_OFS_STROBE, 32'h1);
      wcal;
      hdr;
      for (w = 0; w < 130; w = w + 1) begin
        getb;
        chk(32'(b), ((w % 128) * 7 + 3) % 256);
      end
      chk(32'(TX_ON), 32'h1);
      off;
    end
  endtask

  // Free-running 50 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // Main sequence; reset is held for twelve cycles first.
  initial begin
    RST = 1'b1;
    CE = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    RSSI_IN = 8'hc0;
    RX_FRAME_IN = 1'b0;
    BYTE_REQ_IN = 1'b0;
    fails = 0;
    samples_checked = 0;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    t_regs;
    t_chan;
    t_pwr;
    t_cca;
    t_ctx;
    t_prbs;
    t_dac;
    t_replay;
    test_done;
  end
endmodule // tb_rcc_top
